// File: floppy_host_model.sv
`timescale 1ns/100ps
// ===========================================
// Host processor reading status bytes
module floppy_host_model (
  input  wire logic       i_core_clk, // Clock
  input  wire logic [7:0] i_data,     // Read data
  input  wire logic       i_data_oe,  // Bus enable
  output logic            o_cs_b,     // Select, low
  output logic      [2:0] o_addr,     // Address
  output logic            o_rd_b      // Read, low
);
  initial begin
    o_cs_b = 1'b1;
    o_addr = 3'h0;
    o_rd_b = 1'b1;
  end

  // request held whole until data taken
  task automatic rd(input logic [2:0] a, input int hold,
                    output logic [7:0] d, output logic ok);
    int n;
    @(negedge i_core_clk);
    o_cs_b = 1'b0;
    o_addr = a;
    o_rd_b = 1'b0;
    n = 0;
    while (i_data_oe !== 1'b1 && n < 8) begin
      @(negedge i_core_clk);
      n++;
    end
    ok = i_data_oe;
    repeat (hold) @(negedge i_core_clk);
    d = i_data;
    o_rd_b = 1'b1;
    o_cs_b = 1'b1;
    // Released address lines float, so show a changed value
    o_addr = ~a;
    repeat (5) @(negedge i_core_clk);
  endtask : rd
endmodule : floppy_host_model

// File: floppy_status_pkg.sv
package floppy_status_pkg;

  // ==========================================================================
  // Host register offsets (three address lines)
  localparam logic [2:0] ADDR_STATUS_A   = 3'h0;
  localparam logic [2:0] ADDR_STATUS_B   = 3'h1;
  // Read of this offset clears the set-reset latches
  localparam logic [2:0] ADDR_FLAG_CLEAR = 3'h7;

  // ==========================================================================
  // Compatibility mode strap values
  localparam logic MODE_BASIC = 1'b0;
  localparam logic MODE_EXT   = 1'b1;

  // ==========================================================================
  // Widths and reset values
  localparam int          DATA_W     = 8;
  localparam int          SYNC_DEPTH = 2;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic        FLAG_RST   = 1'b0;

  // ==========================================================================
  // Drive-state result byte field positions
  localparam int DS_UNIT_LO = 0;
  localparam int DS_UNIT_HI = 1;
  localparam int DS_SIDE    = 2;
  localparam int DS_WP_LO   = 3;
  localparam int DS_TRACK0  = 4;
  localparam int DS_READY   = 5;
  localparam int DS_WP_HI   = 6;
  localparam int DS_UNUSED  = 7;

  // ==========================================================================
  // Fixed bit values
  localparam logic DRIVE_READY_VAL = 1'b1;
  localparam logic UNUSED_ZERO     = 1'b0;
  localparam logic RESERVED_ONE    = 1'b1;

endpackage : floppy_status_pkg

// File: floppy_status_readback.sv
`timescale 1ns/100ps

// ============================================================================
// Status readback for the floppy subsystem host interface
module floppy_status_readback (
  input  wire logic       i_core_clk,          // Core clock, 100 MHz
  input  wire logic       i_rst_b,             // Async reset, active low
  // Host bus pins
  input  wire logic       i_cs_b,              // Chip select, active low
  input  wire logic [2:0] i_addr,              // Register address
  input  wire logic       i_rd_b,              // Read strobe, active low
  output logic      [7:0] o_data,              // Read data
  output logic            o_data_oe,           // Data bus drive enable
  // Configuration strap
  input  wire logic       i_mode_ext,          // 1 extended, 0 basic
  // Drive pins (asynchronous)
  input  wire logic       i_write_protect,     // Write protect, high true
  input  wire logic       i_index,             // Index, high true
  input  wire logic       i_track_zero,        // Track zero, high true
  input  wire logic       i_second_drive,      // Second drive installed
  // Controller logic, same clock
  input  wire logic       i_direction,         // Step direction out
  input  wire logic       i_side_select,       // Head select out
  input  wire logic [1:0] i_unit_select,       // Unit select outs
  input  wire logic       i_step,              // Step pulse, high
  input  wire logic       i_interrupt,         // Interrupt request
  input  wire logic       i_dma_request,       // DMA request
  input  wire logic [3:0] i_motor_en,          // Motor enables 0-3
  input  wire logic [3:0] i_drive_sel,         // Decoded selects 0-3
  input  wire logic       i_dor_sel0,          // Output reg select bit 0
  input  wire logic       i_write_en_b,        // Write enable, low
  input  wire logic       i_read_data_pulse_n, // Read data pulse, low
  input  wire logic       i_write_data_pulse_n,// Write data pulse, low
  // Drive-state result byte
  output logic      [7:0] o_drive_state        // Result byte
);

  // ==========================================================================
  // Pin synchronisers
  logic [4:0] host_async;
  logic [4:0] host_s;
  logic [3:0] drv_async;
  logic [3:0] drv_s;
  logic       cs_s_b;
  logic [2:0] addr_s;
  logic       rd_s_b;
  logic       wp_s;
  logic       index_s;
  logic       track0_s;
  logic       second_s;

  assign host_async = {i_cs_b, i_addr, i_rd_b};
  assign drv_async  = {i_write_protect, i_index, i_track_zero,
                       i_second_drive};

  // Select and strobe idle high, else a read is seen after reset
  status_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h11)
  ) u_host_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    (host_async),
    .o_sync     (host_s)
  );

  status_sync #(
    .WIDTH (4)
  ) u_drive_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    (drv_async),
    .o_sync     (drv_s)
  );

  // Synchronised fields
  assign cs_s_b   = host_s[4];
  assign addr_s   = host_s[3:1];
  assign rd_s_b   = host_s[0];
  assign wp_s     = drv_s[3];
  assign index_s  = drv_s[2];
  assign track0_s = drv_s[1];
  assign second_s = drv_s[0];

  // ==========================================================================
  // Edge detection of strobes and internal pulses
  logic rd_prev_q;
  logic step_prev_q;
  logic rdd_prev_q;
  logic wd_prev_q;
  logic we_prev_q;

  // Idle levels at reset so no false edge after release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_prev_q   <= 1'b1;
      step_prev_q <= 1'b0;
      rdd_prev_q  <= 1'b1;
      wd_prev_q   <= 1'b1;
      we_prev_q   <= 1'b1;
    end else begin
      rd_prev_q   <= rd_s_b;
      step_prev_q <= i_step;
      rdd_prev_q  <= i_read_data_pulse_n;
      wd_prev_q   <= i_write_data_pulse_n;
      we_prev_q   <= i_write_en_b;
    end
  end

  logic read_active;
  logic read_start;
  logic clear_read;
  logic step_evt;
  logic rdd_evt;
  logic wd_evt;
  logic we_evt;

  // Writes never reach this block, so status is read-only
  assign read_active = ~cs_s_b & ~rd_s_b;
  assign read_start  = read_active & rd_prev_q;
  assign clear_read  = read_start &
                       (addr_s == floppy_status_pkg::ADDR_FLAG_CLEAR);
  assign step_evt    = i_step & ~step_prev_q;
  assign rdd_evt     = rdd_prev_q & ~i_read_data_pulse_n;
  assign wd_evt      = wd_prev_q & ~i_write_data_pulse_n;
  assign we_evt      = we_prev_q & ~i_write_en_b;

  // ==========================================================================
  // Latched status bits
  logic step_flag;
  logic we_flag;
  logic rdd_flag;
  logic wd_flag;
  logic rdd_tgl;
  logic wd_tgl;

  status_event_flag #(
    .TOGGLE (1'b0)
  ) u_step_flag (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (step_evt),
    .i_clear    (clear_read),
    .o_flag     (step_flag)
  );

  status_event_flag #(
    .TOGGLE (1'b0)
  ) u_we_flag (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (we_evt),
    .i_clear    (clear_read),
    .o_flag     (we_flag)
  );

  status_event_flag #(
    .TOGGLE (1'b0)
  ) u_rdd_flag (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (rdd_evt),
    .i_clear    (clear_read),
    .o_flag     (rdd_flag)
  );

  status_event_flag #(
    .TOGGLE (1'b0)
  ) u_wd_flag (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (wd_evt),
    .i_clear    (clear_read),
    .o_flag     (wd_flag)
  );

  // read data toggle, never cleared by reads
  status_event_flag #(
    .TOGGLE (1'b1)
  ) u_rdd_tgl (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (rdd_evt),
    .i_clear    (1'b0),
    .o_flag     (rdd_tgl)
  );

  // write data toggle, ignores write enable
  status_event_flag #(
    .TOGGLE (1'b1)
  ) u_wd_tgl (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (wd_evt),
    .i_clear    (1'b0),
    .o_flag     (wd_tgl)
  );

  // ==========================================================================
  // Register images for each mode
  logic [7:0] sra_ext;
  logic [7:0] sra_basic;
  logic [7:0] srb_ext;
  logic [7:0] srb_basic;
  logic [3:0] gated_sel;

  // extended status A, polarity per bit
  assign sra_ext = {i_interrupt, ~second_s, i_step, ~track0_s,
                    i_side_select, ~index_s, ~wp_s, i_direction};

  // basic status A live bits and step latch
  assign sra_basic = {i_interrupt, i_dma_request, step_flag, track0_s,
                      i_side_select, index_s, wp_s, i_direction};

  // extended status B, reserved ones on top
  // only the output register select bit 0
  assign srb_ext = {floppy_status_pkg::RESERVED_ONE,
                    floppy_status_pkg::RESERVED_ONE,
                    i_dor_sel0, wd_tgl, rdd_tgl,
                    ~i_write_en_b, i_motor_en[1], i_motor_en[0]};

  // each select qualified by its own motor
  assign gated_sel = i_drive_sel & i_motor_en;

  // basic status B layout, bit 7 zero
  assign srb_basic = {floppy_status_pkg::UNUSED_ZERO,
                      gated_sel[1], gated_sel[0],
                      wd_flag, rdd_flag, we_flag,
                      gated_sel[3], gated_sel[2]};

  // ==========================================================================
  // Host read decode
  logic [7:0] reg_a;
  logic [7:0] reg_b;
  logic       hit_a;
  logic       hit_b;
  logic [7:0] data_d;
  logic       oe_d;

  // strap picks the layout of both registers
  assign reg_a = (i_mode_ext == floppy_status_pkg::MODE_EXT) ?
                 sra_ext : sra_basic;
  assign reg_b = (i_mode_ext == floppy_status_pkg::MODE_EXT) ?
                 srb_ext : srb_basic;

  assign hit_a = read_active &
                 (addr_s == floppy_status_pkg::ADDR_STATUS_A);
  assign hit_b = read_active &
                 (addr_s == floppy_status_pkg::ADDR_STATUS_B);

  // Other offsets belong to other blocks, so the bus is left alone
  assign oe_d   = hit_a | hit_b;
  assign data_d = hit_a ? reg_a :
                  hit_b ? reg_b : floppy_status_pkg::DATA_RST;

  // Data follows live bits for as long as the strobe is held
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data    <= floppy_status_pkg::DATA_RST;
      o_data_oe <= 1'b0;
    end else begin
      o_data    <= data_d;
      o_data_oe <= oe_d;
    end
  end

  // ==========================================================================
  // Drive-state result byte
  logic [7:0] drive_state_d;

  always_comb begin
    drive_state_d = floppy_status_pkg::DATA_RST;
    drive_state_d[floppy_status_pkg::DS_UNUSED] =
      floppy_status_pkg::UNUSED_ZERO;
    drive_state_d[floppy_status_pkg::DS_WP_HI]  = wp_s;
    drive_state_d[floppy_status_pkg::DS_WP_LO]  = wp_s;
    drive_state_d[floppy_status_pkg::DS_READY]  =
      floppy_status_pkg::DRIVE_READY_VAL;
    drive_state_d[floppy_status_pkg::DS_TRACK0] = track0_s;
    drive_state_d[floppy_status_pkg::DS_SIDE]   = i_side_select;
    drive_state_d[floppy_status_pkg::DS_UNIT_HI] = i_unit_select[1];
    drive_state_d[floppy_status_pkg::DS_UNIT_LO] = i_unit_select[0];
  end

  // Registered so the result byte never glitches to its reader
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_drive_state <= floppy_status_pkg::DATA_RST;
    end else begin
      o_drive_state <= drive_state_d;
    end
  end

endmodule : floppy_status_readback

// File: floppy_status_readback_asserts.sv
`timescale 1ns/100ps
// ===========================================
// Port checks beside the status readback
module floppy_status_readback_asserts (
  input  wire logic       i_core_clk,    // Clock
  input  wire logic       i_rst_b,       // Reset, low
  input  wire logic       i_cs_b,        // Select, low
  input  wire logic [2:0] i_addr,        // Address
  input  wire logic       i_rd_b,        // Read, low
  input  wire logic       i_mode_ext,    // Layout strap
  input  wire logic       i_step,        // Step pulse
  input  wire logic       i_side_select, // Side out
  input  wire logic [1:0] i_unit_select, // Unit outs
  input  wire logic [7:0] o_data,        // Read data
  input  wire logic       o_data_oe,     // Bus enable
  input  wire logic [7:0] o_drive_state  // Result byte
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Result byte fixed and mirrored bits
  chk_unused_zero: assert property (o_drive_state[7] == 1'b0)
    else $error("result bit 7 not zero");
  chk_wp_pair: assert property (o_drive_state[6] == o_drive_state[3])
    else $error("write protect copies differ");
  // First edge after release still shows the reset value
  chk_ready_one: assert property ($past(i_rst_b) |->
    o_drive_state[5] == 1'b1) else $error("ready bit low");
  chk_side_unit: assert property ($past(i_rst_b) |->
    o_drive_state[2:0] == $past({i_side_select, i_unit_select}))
    else $error("side or unit bits wrong");

  // Host bus enable follows the synchronised strobe
  chk_oe_cause: assert property ($rose(o_data_oe) |->
    $past(!i_cs_b && !i_rd_b && i_addr < 3'h2, 3))
    else $error("bus driven without read");
  chk_oe_drop: assert property ($rose(i_rd_b) |->
    ##[2:4] (o_data_oe == 1'b0)) else $error("bus not released");
  chk_ext_b_ones: assert property (o_data_oe && i_mode_ext &&
    $past(i_addr, 3) == 3'h1 && i_addr == 3'h1 |->
    o_data[7:6] == 2'b11) else $error("reserved bits not one");
  chk_basic_b_top: assert property (o_data_oe && !i_mode_ext &&
    $past(i_addr, 3) == 3'h1 && i_addr == 3'h1 |->
    o_data[7] == 1'b0) else $error("basic B bit 7 not zero");
  chk_step_seen: assert property ($rose(i_step) && o_data_oe &&
    !i_mode_ext && i_addr == 3'h0 |-> ##[1:4] o_data[5] == 1'b1)
    else $error("step latch not shown");
endmodule : floppy_status_readback_asserts

// File: floppy_status_readback_tb.sv
`timescale 1ns/100ps
// ===========================================
// Self-checking bench for the status readback
module floppy_status_readback_tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cs_b, rd_b, oe, ok;
  logic [2:0] addr;
  logic [7:0] data, ds, got;
  logic       mode = 1'b1;
  logic       wp = 0, idx = 0, t0 = 0, sec = 0, dir = 0, side = 0;
  logic       stp = 0, irq = 0, dma = 0, dsel0 = 0;
  logic       we_b = 1, rdd_n = 1, wd_n = 1;
  logic [1:0] unit = 2'h0;
  logic [3:0] mot = 4'h0, sel = 4'h0;
  int         num_errors = 0;
  int         checks = 0;

  always #5 clk = ~clk;

  floppy_status_readback u_floppy_status_readback (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b),
    .i_addr(addr), .i_rd_b(rd_b), .o_data(data), .o_data_oe(oe),
    .i_mode_ext(mode), .i_write_protect(wp), .i_index(idx),
    .i_track_zero(t0), .i_second_drive(sec), .i_direction(dir),
    .i_side_select(side), .i_unit_select(unit), .i_step(stp),
    .i_interrupt(irq), .i_dma_request(dma), .i_motor_en(mot),
    .i_drive_sel(sel), .i_dor_sel0(dsel0), .i_write_en_b(we_b),
    .i_read_data_pulse_n(rdd_n), .i_write_data_pulse_n(wd_n),
    .o_drive_state(ds));

  floppy_host_model u_floppy_host_model (
    .i_core_clk(clk), .i_data(data), .i_data_oe(oe),
    .o_cs_b(cs_b), .o_addr(addr), .o_rd_b(rd_b));

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // Read that must be answered, then its byte
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    u_floppy_host_model.rd(a, 0, got, ok);
    cmp({7'h0, ok}, 8'h01);
    cmp(got, e);
  endtask : rdc

  // One-cycle event, then idle so the next edge is seen
  task automatic pulse(input int w);
    @(negedge clk);
    case (w)
      0: stp = 1'b1;
      1: rdd_n = 1'b0;
      2: wd_n = 1'b0;
      default: we_b = 1'b0;
    endcase
    @(negedge clk);
    stp = 1'b0;
    rdd_n = 1'b1;
    wd_n = 1'b1;
    we_b = 1'b1;
    @(negedge clk);
  endtask : pulse

  // Strap only changes while held in reset
  task automatic dres(input logic m);
    @(negedge clk);
    rst_b = 1'b0;
    mode = m;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
  endtask : dres

  task automatic close_out;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  initial begin
    dres(1'b1);
    {wp, t0, side, unit} = 5'h1E;
    repeat (4) @(negedge clk);
    cmp(ds, 8'h7E);
    {wp, t0, side, unit} = 5'h01;
    repeat (4) @(negedge clk);
    cmp(ds, 8'h21);
    $display("result byte test done");
    {dir, idx, side, irq} = 4'hF;
    rdc(3'h0, 8'hDB);
    u_floppy_host_model.rd(3'h2, 0, got, ok);
    cmp({7'h0, ok}, 8'h00);
    {wp, t0, sec, dir, irq} = 5'h1C;
    rdc(3'h0, 8'h08);
    mot = 4'h1;
    dsel0 = 1'b1;
    we_b = 1'b0;
    rdc(3'h1, 8'hE5);
    pulse(1);
    pulse(2);
    rdc(3'h1, 8'hF9);
    pulse(2);
    rdc(3'h1, 8'hE9);
    $display("extended layout test done");
    dres(1'b0);
    {dir, wp, idx, side, t0, dma, irq} = 7'h4E;
    rdc(3'h0, 8'h59);
    fork
      u_floppy_host_model.rd(3'h0, 8, got, ok);
      begin
        repeat (6) @(negedge clk);
        pulse(0);
      end
    join
    cmp(got, 8'h79);
    rdc(3'h0, 8'h79);
    u_floppy_host_model.rd(3'h7, 0, got, ok);
    rdc(3'h0, 8'h59);
    sel = 4'hF;
    mot = 4'h5;
    rdc(3'h1, 8'h21);
    pulse(3);
    pulse(1);
    pulse(2);
    rdc(3'h1, 8'h3D);
    u_floppy_host_model.rd(3'h7, 0, got, ok);
    rdc(3'h1, 8'h21);
    pulse(0);
    pulse(1);
    dres(1'b0);
    rdc(3'h1, 8'h21);
    rdc(3'h0, 8'h59);
    $display("basic layout test done");
    close_out();
  end

  // Whole run is a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule : floppy_status_readback_tb

bind floppy_status_readback floppy_status_readback_asserts u_chk (
  .i_core_clk, .i_rst_b, .i_cs_b, .i_addr, .i_rd_b, .i_mode_ext,
  .i_step, .i_side_select, .i_unit_select, .o_data, .o_data_oe,
  .o_drive_state);

// File: status_event_flag.sv
`timescale 1ns/100ps

// ============================================================================
// Event flag: set-reset latch or toggle flip-flop
module status_event_flag #(
  parameter bit TOGGLE = 1'b0
) (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_rst_b,    // Async reset, active low
  input  wire logic i_event,    // One-cycle event pulse
  input  wire logic i_clear,    // One-cycle clear pulse
  output logic      o_flag      // Flag state
);

  logic flag_d;

  // Set beats clear so a colliding event is never lost
  assign flag_d = TOGGLE ? (o_flag ^ i_event)
                         : (i_event | (o_flag & ~i_clear));

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag <= floppy_status_pkg::FLAG_RST;
    end else begin
      o_flag <= flag_d;
    end
  end

endmodule : status_event_flag

// File: status_sync.sv
`timescale 1ns/100ps

// ============================================================================
// Two-stage synchroniser for asynchronous pin levels
module status_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_core_clk, // Core clock
  input  wire logic             i_rst_b,    // Async reset, active low
  input  wire logic [WIDTH-1:0] i_async,    // Asynchronous levels
  output logic      [WIDTH-1:0] o_sync      // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  // Reset to idle pin levels, so no false request follows release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : status_sync
